// >>> msrc_board.sv
`timescale 1ns/1ps
// ------------------------------------------
// Board reset circuit and devices on the lines
// ------------------------------------------
module msrc_board (
    // Clock
    input  wire logic clk,
    // Requests from the bench
    input  wire logic por_req,
    input  wire logic hard_pull,
    input  wire logic soft_pull,
    // Open-drain enables of the controller
    input  wire logic hard_oe,
    input  wire logic soft_oe,
    // Resolved levels
    output logic      power_on_reset_in_n,
    output logic      hard_line,
    output logic      soft_line
);
    logic [4:0] hold_reg;

    // Pin stays low 16 more clocks after power is good
    always_ff @(posedge clk) begin
        if (por_req)
            hold_reg <= 5'h10;
        else if (hold_reg != 5'h00)
            hold_reg <= hold_reg - 5'h01;
    end
    assign power_on_reset_in_n = !(por_req || hold_reg != 5'h00);

    // Pull-ups: a line is low while any party pulls it, never driven high
    assign hard_line = !(hard_oe || hard_pull);
    assign soft_line = !(soft_oe || soft_pull);
endmodule : msrc_board

// >>> msrc_pkg.sv
package msrc_pkg;

    // ----------------------------------------------------------------
    // Sequence lengths in controller clock cycles
    // ----------------------------------------------------------------
    localparam logic [11:0] POR_STRETCH_CYC = 12'h400; // After pin release
    localparam logic [11:0] HARD_HOLD_CYC   = 12'h200; // Hard line hold
    localparam logic [11:0] SOFT_HOLD_CYC   = 12'h203; // Soft-only hold
    localparam logic [11:0] SOFT_TAIL_CYC   = 12'h003; // Soft after hard

    // ----------------------------------------------------------------
    // Reset status bit positions
    // ----------------------------------------------------------------
    localparam int unsigned ST_POR      = 0;
    localparam int unsigned ST_EXT_HARD = 1;
    localparam int unsigned ST_EXT_SOFT = 2;
    localparam int unsigned ST_WDOG     = 3;
    localparam int unsigned ST_BMON     = 4;
    localparam int unsigned ST_JTAG     = 5;
    localparam int unsigned ST_WIDTH    = 6;

    // ----------------------------------------------------------------
    // Internal request sources handled by the request latch
    // ----------------------------------------------------------------
    localparam int unsigned SRC_WDOG = 0;
    localparam int unsigned SRC_BMON = 1;
    localparam int unsigned NUM_INT  = 2;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [ST_WIDTH-1:0] STATUS_RST   = 6'h00;
    localparam logic [31:0]         CFG_WORD_RST = 32'h0000_0000;
    localparam logic [1:0]          CLK_MODE_RST = 2'h0;
    localparam logic [2:0]          BOOT_RST     = 3'h0;
    localparam logic [3:0]          CHIP_ID_RST  = 4'h0;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE        = 3'h0,
        S_POR_HOLD    = 3'h1,
        S_POR_STRETCH = 3'h2,
        S_HARD        = 3'h3,
        S_SOFT        = 3'h4,
        S_RELEASE     = 3'h5
    } msrc_state_t;

endpackage : msrc_pkg

// >>> msrc_req_if.sv
`timescale 1ns/1ps
interface msrc_req_if;
    logic [1:0] pend;
    logic [1:0] take;
    modport latch (output pend, input take);
    modport ctrl  (input pend, output take);
endinterface : msrc_req_if

// >>> msrc_req_latch.sv
`timescale 1ns/1ps
module msrc_req_latch
    import msrc_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Internal expiry events and their enables
    input  wire logic wdog_expire,
    input  wire logic wdog_enable,
    input  wire logic bmon_expire,
    input  wire logic bmon_enable,
    // Pending requests toward the sequencer
    msrc_req_if.latch req
);

    wire logic [NUM_INT-1:0] raw_req;
    logic      [NUM_INT-1:0] sync1_reg;
    logic      [NUM_INT-1:0] sync2_reg;
    logic      [NUM_INT-1:0] pend_reg;

    // Only enabled counters may request a reset
    assign raw_req[SRC_WDOG] = wdog_expire & wdog_enable;
    assign raw_req[SRC_BMON] = bmon_expire & bmon_enable;
    assign req.pend          = pend_reg;

    // Synchronise and hold each request until the sequencer takes it;
    // a fresh request in the take cycle wins so none is lost
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INT; gi++) begin : g_src
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                    pend_reg[gi]  <= 1'b0;
                end else begin
                    sync1_reg[gi] <= raw_req[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    pend_reg[gi]  <= sync2_reg[gi]
                                   | (pend_reg[gi] & ~req.take[gi]);
                end
            end

            a_pulse_latched:
            assert property (@(posedge clk) disable iff (!rst_n)
                sync2_reg[gi] |=> pend_reg[gi])
                else $error("Synchronised request not latched");
        end
    endgenerate

endmodule : msrc_req_latch

// >>> msrc_reset_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - All six reset sources enter one controller choosing actions by source.
// - A status vector records which sources caused the latest reset.
// - Power-on resets everything, PLL and DLL too, drives both lines.
// - Clock, config, boot mode, chip id, port width captured only at power-on.
// - Pin sampling and PLL/DLL reset happen only on power-on reset.
// - Slave-port config write after power-on only; system bus also after hard.
// - Soft reset line is held whenever the hard reset line is driven.
// - Hard reset line is open-drain; either side may pull it low.
// - Hard reset drives both lines, resets cores, reloads 32-bit config word.
// - External soft assertion counts only while this block drives no reset.
// - Soft reset drives soft line, resets cores, keeps system configuration.
// - Enabled watchdog expiry starts an internal hard reset sequence.
// - Enabled bus monitor expiry starts an internal hard reset sequence.
// - Test port host reset command starts a soft reset sequence.
// - Every reset type resets peripheral modules, cores and quad bus.
// - Power-on and hard resets drive both lines and reset the cores.
// - Configuration pins are captured when the power-on input releases.
module msrc_reset_ctrl
    import msrc_pkg::*;
(
    // Clock and controller reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Power-on reset pin, active low
    input  wire logic        power_on_reset_in_n,
    // Open-drain hard and soft reset lines, low means reset
    input  wire logic        hard_reset_line_in,
    output logic             hard_reset_line_out,
    output logic             hard_reset_line_oe,
    input  wire logic        soft_reset_line_in,
    output logic             soft_reset_line_out,
    output logic             soft_reset_line_oe,
    // Internal reset requests
    input  wire logic        wdog_expire,
    input  wire logic        wdog_enable,
    input  wire logic        bmon_expire,
    input  wire logic        bmon_enable,
    input  wire logic        jtag_host_reset,
    // Configuration pins sampled at power-on release
    input  wire logic [1:0]  clock_mode_select,
    input  wire logic        cfg_rst_mode_pin,
    input  wire logic [2:0]  cfg_boot_pin,
    input  wire logic [3:0]  cfg_chip_id_pin,
    input  wire logic        cfg_slave64_pin,
    // Hard reset configuration word writes
    input  wire logic [31:0] cfg_word_in,
    input  wire logic        cfg_word_dsi_valid,
    input  wire logic        cfg_word_bus_valid,
    // Captured configuration
    output logic [1:0]       clock_mode,
    output logic             rst_conf_mode,
    output logic [2:0]       boot_mode,
    output logic [3:0]       chip_id,
    output logic             slave_port_64,
    output logic [31:0]      hard_cfg_word,
    // Reset actions
    output logic             system_pll_dll_reset,
    output logic             system_interface_unit_reset,
    output logic             peripheral_bus_reset,
    output logic             core_reset,
    output logic             quad_bus_subsystem_reset,
    output logic             dsi_cfg_write_en,
    output logic             bus_cfg_write_en,
    // Cause of the latest reset
    output logic [5:0]       reset_status
);

    // ----------------------------------------------------------------
    // Request latch for internal hard reset sources
    // ----------------------------------------------------------------
    msrc_req_if req_if ();
    msrc_req_latch u_req (
        .clk         (clk),
        .rst_n       (rst_n),
        .wdog_expire (wdog_expire),
        .wdog_enable (wdog_enable),
        .bmon_expire (bmon_expire),
        .bmon_enable (bmon_enable),
        .req         (req_if.latch)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    msrc_state_t           state_reg;
    msrc_state_t           state_next;
    logic [11:0]           cnt_reg;
    logic [11:0]           cnt_next;
    logic                  por_seq_reg;
    logic                  por_seq_next;
    logic [ST_WIDTH-1:0]   status_reg;
    logic [ST_WIDTH-1:0]   status_next;
    logic                  drive_hard_reg;
    logic                  drive_soft_reg;
    logic                  pll_rst_reg;
    logic                  dsi_en_reg;
    logic                  bus_en_reg;

    // ----------------------------------------------------------------
    // Source decoding
    // ----------------------------------------------------------------
    // External line assertions are only seen while this block is quiet,
    // so its own drive is never mistaken for a new request
    wire logic por_active = ~power_on_reset_in_n;
    wire logic idle       = (state_reg == S_IDLE);
    wire logic ext_hard   = idle & ~hard_reset_line_in;
    wire logic ext_soft   = idle & ~soft_reset_line_in;
    wire logic wdog_hard  = req_if.pend[SRC_WDOG];
    wire logic bmon_hard  = req_if.pend[SRC_BMON];
    wire logic hard_go    = ext_hard | wdog_hard | bmon_hard;
    wire logic soft_go    = ext_soft | (idle & jtag_host_reset);
    wire logic can_start  = idle | (state_reg == S_SOFT)
                          | (state_reg == S_RELEASE);
    wire logic cnt_zero   = (cnt_reg == 12'h000);
    wire logic lines_high = hard_reset_line_in & soft_reset_line_in;
    wire logic enter_hard = (state_next == S_HARD)
                          & (state_reg != S_HARD);
    wire logic cfg_capture = (state_reg == S_POR_HOLD) & ~por_active;
    // Causes recorded when each kind of sequence starts
    wire logic [ST_WIDTH-1:0] hard_cause = {1'b0, bmon_hard, wdog_hard,
                                            1'b0, ext_hard, 1'b0};
    wire logic [ST_WIDTH-1:0] soft_cause = {idle & jtag_host_reset,
                                            2'b00, ext_soft, 2'b00};
    assign req_if.take = {bmon_hard, wdog_hard} & {2{enter_hard}};

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Power-on preempts everything and internal hard preempts a running soft
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        por_seq_next = por_seq_reg;
        status_next  = status_reg;
        if (por_active && state_reg != S_POR_HOLD) begin
            state_next   = S_POR_HOLD;
            por_seq_next = 1'b1;
            status_next  = '0;
            status_next[ST_POR] = 1'b1;
        end else if (can_start && hard_go) begin
            state_next   = S_HARD;
            cnt_next     = HARD_HOLD_CYC;
            por_seq_next = 1'b0;
            status_next  = hard_cause;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (soft_go) begin
                        state_next   = S_SOFT;
                        cnt_next     = SOFT_HOLD_CYC;
                        por_seq_next = 1'b0;
                        status_next  = soft_cause;
                    end
                end
                S_POR_HOLD: begin
                    if (!por_active) begin
                        state_next = S_POR_STRETCH;
                        cnt_next   = POR_STRETCH_CYC;
                    end
                end
                S_POR_STRETCH: begin
                    if (cnt_zero) begin
                        state_next = S_HARD;
                        cnt_next   = HARD_HOLD_CYC;
                    end else begin
                        cnt_next = cnt_reg - 12'h001;
                    end
                end
                S_HARD: begin
                    // Soft line outlasts the hard line by a short tail
                    if (cnt_zero) begin
                        state_next = S_SOFT;
                        cnt_next   = SOFT_TAIL_CYC;
                    end else begin
                        cnt_next = cnt_reg - 12'h001;
                    end
                end
                S_SOFT: begin
                    if (cnt_zero) begin
                        state_next = S_RELEASE;
                    end else begin
                        cnt_next = cnt_reg - 12'h001;
                    end
                end
                S_RELEASE: begin
                    // Wait for other agents to let the lines go
                    if (lines_high) begin
                        state_next = S_IDLE;
                    end
                end
                default: begin
                    state_next = S_IDLE;
                end
            endcase
        end
    end

    // Action decoding from the next state keeps outputs registered
    wire logic in_por   = (state_next == S_POR_HOLD)
                        | (state_next == S_POR_STRETCH);
    wire logic hard_nx  = in_por | (state_next == S_HARD);
    wire logic soft_nx  = hard_nx | (state_next == S_SOFT);
    wire logic bus_nx   = (state_next == S_HARD);
    wire logic dsi_nx   = bus_nx & por_seq_next;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= S_IDLE;
            cnt_reg        <= 12'h000;
            por_seq_reg    <= 1'b0;
            status_reg     <= STATUS_RST;
            drive_hard_reg <= 1'b0;
            drive_soft_reg <= 1'b0;
            pll_rst_reg    <= 1'b0;
            dsi_en_reg     <= 1'b0;
            bus_en_reg     <= 1'b0;
        end else begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            por_seq_reg    <= por_seq_next;
            status_reg     <= status_next;
            drive_hard_reg <= hard_nx;
            drive_soft_reg <= soft_nx;
            pll_rst_reg    <= in_por;
            dsi_en_reg     <= dsi_nx;
            bus_en_reg     <= bus_nx;
        end
    end

    // ----------------------------------------------------------------
    // Configuration capture
    // ----------------------------------------------------------------
    // Pins are caught only on power-on release; hard and soft keep them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_mode    <= CLK_MODE_RST;
            rst_conf_mode <= 1'b0;
            boot_mode     <= BOOT_RST;
            chip_id       <= CHIP_ID_RST;
            slave_port_64 <= 1'b0;
        end else if (cfg_capture) begin
            clock_mode    <= clock_mode_select;
            rst_conf_mode <= cfg_rst_mode_pin;
            boot_mode     <= cfg_boot_pin;
            chip_id       <= cfg_chip_id_pin;
            slave_port_64 <= cfg_slave64_pin;
        end
    end

    // Hard reset config word: default at power-on, then reloaded by
    // a write inside the window; soft resets leave it alone
    wire logic word_wr = (dsi_en_reg & cfg_word_dsi_valid)
                       | (bus_en_reg & cfg_word_bus_valid);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hard_cfg_word <= CFG_WORD_RST;
        end else if (cfg_capture) begin
            hard_cfg_word <= CFG_WORD_RST;
        end else if (word_wr) begin
            hard_cfg_word <= cfg_word_in;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Open-drain: only ever drive low, enable marks active pull-down
    assign hard_reset_line_out = 1'b0;
    assign hard_reset_line_oe  = drive_hard_reg;
    assign soft_reset_line_out = 1'b0;
    assign soft_reset_line_oe  = drive_soft_reg;
    assign system_pll_dll_reset        = pll_rst_reg;
    assign system_interface_unit_reset = drive_hard_reg;
    assign peripheral_bus_reset        = drive_soft_reg;
    assign core_reset                  = drive_soft_reg;
    assign quad_bus_subsystem_reset    = drive_soft_reg;
    assign dsi_cfg_write_en            = dsi_en_reg;
    assign bus_cfg_write_en            = bus_en_reg;
    assign reset_status                = status_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_hard_soft_pair:
    assert property (@(posedge clk) disable iff (!rst_n)
        hard_reset_line_oe |-> soft_reset_line_oe)
        else $error("Hard line driven without soft line");
    a_por_full_reset:
    assert property (@(posedge clk) disable iff (!rst_n)
        (por_active && state_reg == S_IDLE) |=> system_pll_dll_reset
        && hard_reset_line_oe && soft_reset_line_oe && core_reset)
        else $error("Power-on did not reset everything");
    a_pll_por_only:
    assert property (@(posedge clk) disable iff (!rst_n)
        system_pll_dll_reset |-> por_seq_reg)
        else $error("PLL reset outside power-on");
    a_cfg_por_only:
    assert property (@(posedge clk) disable iff (!rst_n)
        $changed(clock_mode) |-> $past(state_reg) == S_POR_HOLD)
        else $error("Clock mode changed outside power-on");
    a_dsi_window:
    assert property (@(posedge clk) disable iff (!rst_n)
        dsi_cfg_write_en |-> (por_seq_reg && bus_cfg_write_en))
        else $error("Slave port config window outside power-on");
    a_soft_ignored:
    assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg != S_IDLE && !por_active && !soft_reset_line_in)
        |=> !$rose(reset_status[ST_EXT_SOFT]))
        else $error("Soft assertion taken during own reset");
    a_wdog_hard:
    assert property (@(posedge clk) disable iff (!rst_n)
        (req_if.pend[SRC_WDOG] && state_reg == S_IDLE && !por_active)
        |=> state_reg == S_HARD ##1 hard_reset_line_oe)
        else $error("Watchdog did not start hard reset");
    a_bmon_hard:
    assert property (@(posedge clk) disable iff (!rst_n)
        (req_if.pend[SRC_BMON] && state_reg == S_IDLE && !por_active)
        |=> reset_status[ST_BMON] && hard_reset_line_oe)
        else $error("Bus monitor did not start hard reset");
    a_jtag_soft:
    assert property (@(posedge clk) disable iff (!rst_n)
        (jtag_host_reset && idle && !por_active && !hard_go)
        |=> soft_reset_line_oe && !hard_reset_line_oe
        && reset_status[ST_JTAG])
        else $error("Host command did not start soft reset");
    a_por_priority:
    assert property (@(posedge clk) disable iff (!rst_n)
        (por_active && (hard_go || soft_go)) |=> state_reg == S_POR_HOLD)
        else $error("Power-on lost to a lesser request");

endmodule : msrc_reset_ctrl

// >>> msrc_reset_ctrl_bench.sv
`timescale 1ns/1ps
module msrc_reset_ctrl_bench;
    // ------------------------------------------
    // Signals
    // ------------------------------------------
    logic        clk, rst_n, por_req, pin_n, hard_in, soft_in;
    logic        hard_oe, soft_oe, soft_oe_d, dsi_v, bus_v, pll, core;
    logic        bm_en, wd_en, system_interface_unit, per, quad, dsi_en, bus_en, h_out, s_out;
    logic [4:0]  kick_v;
    logic [5:0]  status;
    logic [10:0] pins, cfg_exp, cfg_seen;
    logic [31:0] word, cfg_word, w_exp;
    // Note: {status, hard oe, pll, core, unit, periph, quad bus}
    logic [11:0] notes[$];
    logic [11:0] tbl[5] = '{12'h0af, 12'h10b, 12'h22f, 12'h42f, 12'h80b};
    logic [11:0] exp_n;
    wire logic [11:0] act = {status, hard_oe, pll, core, system_interface_unit, per, quad};
    int          n_errors, n_compared, seed;

    msrc_board board_u (.clk(clk), .por_req(por_req),
        .hard_pull(kick_v[0]), .soft_pull(kick_v[1]), .hard_oe(hard_oe),
        .soft_oe(soft_oe), .power_on_reset_in_n(pin_n),
        .hard_line(hard_in), .soft_line(soft_in));

    msrc_reset_ctrl dut_u (.clk(clk), .rst_n(rst_n),
        .power_on_reset_in_n(pin_n), .hard_reset_line_in(hard_in),
        .hard_reset_line_out(h_out), .hard_reset_line_oe(hard_oe),
        .soft_reset_line_in(soft_in), .soft_reset_line_out(s_out),
        .soft_reset_line_oe(soft_oe), .wdog_expire(kick_v[2]),
        .wdog_enable(wd_en), .bmon_expire(kick_v[3]), .bmon_enable(bm_en),
        .jtag_host_reset(kick_v[4]), .clock_mode_select(pins[10:9]),
        .cfg_rst_mode_pin(pins[8]), .cfg_boot_pin(pins[7:5]),
        .cfg_chip_id_pin(pins[4:1]), .cfg_slave64_pin(pins[0]),
        .cfg_word_in(word), .cfg_word_dsi_valid(dsi_v),
        .cfg_word_bus_valid(bus_v), .clock_mode(cfg_seen[10:9]),
        .rst_conf_mode(cfg_seen[8]), .boot_mode(cfg_seen[7:5]),
        .chip_id(cfg_seen[4:1]), .slave_port_64(cfg_seen[0]),
        .hard_cfg_word(cfg_word), .system_pll_dll_reset(pll),
        .system_interface_unit_reset(system_interface_unit), .peripheral_bus_reset(per),
        .core_reset(core), .quad_bus_subsystem_reset(quad),
        .dsi_cfg_write_en(dsi_en), .bus_cfg_write_en(bus_en),
        .reset_status(status));

    // ------------------------------------------
    // Checking and closing
    // ------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // Bounded wait until neither line is driven, then let RELEASE settle
    task automatic wait_quiet;
        int i;
        i = 0;
        repeat (6) @(posedge clk);
        while ((hard_oe || soft_oe) && i < 3000) begin
            @(posedge clk);
            i++;
        end
        if (i == 3000) begin
            n_errors++;
            test_done();
        end
        repeat (3) @(posedge clk);
    endtask : wait_quiet

    // One-cycle request from one source, with its expected note queued
    task automatic kick(input int k);
        notes.push_back(tbl[k]);
        kick_v <= 5'h01 << k;
        @(posedge clk);
        kick_v <= 5'h00;
        wait_quiet();
        $display("test %0d done", k);
    endtask : kick

    // Each reset start is matched with the oldest note
    always @(posedge clk) begin
        #1;
        if (soft_oe && !soft_oe_d) begin
            exp_n = notes.size() > 0 ? notes.pop_front() : 12'hfff;
            check(32'(act), 32'(exp_n));
        end
        soft_oe_d = soft_oe;
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end

    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        n_errors = 0;
        n_compared = 0;
        seed = 32'hfe2c;
        {rst_n, soft_oe_d, dsi_v, bus_v, kick_v, word} = '0;
        por_req = 1'b1;
        bm_en = 1'b1;
        wd_en = 1'b1;
        pins = 11'($random(seed));
        cfg_exp = pins;
        notes.push_back(12'h07f);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        por_req <= 1'b0;
        wait_quiet();
        check(32'(cfg_seen), 32'(cfg_exp));
        $display("test por done");
        pins <= 11'($random(seed));
        // Hard reset: slave-port write refused, bus write taken, soft ignored
        notes.push_back(tbl[0]);
        w_exp = $random(seed);
        kick_v <= 5'h01;
        repeat (10) @(posedge clk);
        check(32'({dsi_en, bus_en}), 32'h1);
        {kick_v, word, dsi_v} <= {5'h02, ~w_exp, 1'b1};
        @(posedge clk);
        {kick_v, word, dsi_v, bus_v} <= {5'h00, w_exp, 1'b0, 1'b1};
        @(posedge clk);
        bus_v <= 1'b0;
        wait_quiet();
        check(32'(status), 32'h2);
        check(cfg_word, w_exp);
        $display("test hard done");
        // Soft, watchdog, bus monitor and test port requests
        for (int k = 1; k < 5; k++)
            kick(k);
        // Disabled watchdog and bus monitor must not start anything
        {wd_en, bm_en} <= 2'b00;
        kick_v <= 5'h0c;
        @(posedge clk);
        kick_v <= 5'h00;
        repeat (8) @(posedge clk);
        check(32'(soft_oe), 32'h0);
        check(32'(cfg_seen), 32'(cfg_exp));
        check(cfg_word, w_exp);
        check(32'({h_out, s_out}), 32'h0);
        $display("test disabled done");
        // Power-on racing a hard pull must win and sample the new pins
        cfg_exp = pins;
        notes.push_back(12'h07f);
        {por_req, kick_v} <= {1'b1, 5'h01};
        @(posedge clk);
        {por_req, kick_v} <= 6'h00;
        wait_quiet();
        check(32'(cfg_seen), 32'(cfg_exp));
        check(cfg_word, 32'h0);
        check(32'(notes.size()), 32'h0);
        $display("test por2 done");
        test_done();
    end
endmodule : msrc_reset_ctrl_bench
